// ===== hdl/adcsq_pkg.sv
// Purpose: shared constants for the converter setup sequencer ends
// Assumes: 50 MHz system clock, 24-bit serial write frames
// Notes:   frame is 8-bit address then 16-bit data, msb first
`default_nettype none
package adcsq_pkg;
    localparam int CLK_NS          = 20;
    localparam int SCLK_HALF_NS    = 80;
    localparam int SCLK_HALF_CYC   = (SCLK_HALF_NS / CLK_NS < 1) ? 1 : SCLK_HALF_NS / CLK_NS;
    localparam int PIN_HOLD_NS     = 200;
    localparam int PIN_HOLD_CYC    = (PIN_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int FRAME_BITS      = 24;

    localparam logic [7:0]  ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0]  ADDR_POWER      = 8'h0F;
    localparam logic [7:0]  ADDR_MODE       = 8'h31;
    localparam logic [7:0]  ADDR_SEL_FIRST  = 8'h3A;
    localparam logic [7:0]  ADDR_SEL_SECOND = 8'h3B;
    localparam logic [7:0]  ADDR_PHASE      = 8'h42;

    localparam logic [15:0] VAL_SOFT_RESET  = 16'h0001;
    localparam logic [15:0] VAL_POWER_DOWN  = 16'h0200;
    localparam logic [15:0] VAL_ACTIVE      = 16'h0000;
    localparam logic [15:0] VAL_MODE_SINGLE = 16'h0001;
    localparam logic [15:0] VAL_MODE_DUAL   = 16'h0102;
    localparam logic [15:0] VAL_SEL_INPUT1  = 16'h0202;
    localparam logic [15:0] VAL_SEL_INPUT2  = 16'h1010;

    localparam int POWER_DOWN_BIT   = 9;
    localparam int MODE_DUAL_BIT    = 8;
    localparam int MODE_DIV2_BIT    = 1;

    localparam logic [15:0] RST_POWER   = 16'h0000;
    localparam logic [15:0] RST_MODE    = VAL_MODE_SINGLE;
    localparam logic [15:0] RST_SEL     = VAL_SEL_INPUT1;
    localparam logic [15:0] RST_PHASE   = 16'h0000;
endpackage
`default_nettype wire

// ===== hdl/adcsq_if.sv
// Purpose: pins between host sequencer and converter control end
// Assumes: host drives all control pins, bench drives the clock pair
// Notes:   all pins one-way, no tristate
`default_nettype none
interface adcsq_if;
    logic active_low_reset_pin;
    logic power_down_pin;
    logic ser_clk;
    logic ser_sel_n;
    logic ser_data;
    logic clock_pos_input;
    logic clock_neg_input;

    modport host
    (
        output active_low_reset_pin,
        output power_down_pin,
        output ser_clk,
        output ser_sel_n,
        output ser_data
    );
    modport device
    (
        input  active_low_reset_pin,
        input  power_down_pin,
        input  ser_clk,
        input  ser_sel_n,
        input  ser_data,
        input  clock_pos_input,
        input  clock_neg_input
    );
endinterface
`default_nettype wire

// ===== hdl/adcsq_device.sv
// Purpose: converter end: serial register file, power down, mode, sampling
// Assumes: pins arrive asynchronous and are double synchronised
// Notes:   write-only serial frames, committed when select rises
`default_nettype none
module adcsq_device
    import adcsq_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    adcsq_if.device          pins,
    output logic             o_powered_down,
    output logic             o_dual_mode,
    output logic             o_div2,
    output logic [15:0]      o_sel_first,
    output logic [15:0]      o_sel_second,
    output logic [15:0]      o_phase,
    output logic             o_sample_pulse
);
    logic [1:0]  s_rst;
    logic [1:0]  s_pd;
    logic [2:0]  s_sck;
    logic [2:0]  s_sel;
    logic [1:0]  s_dat;
    logic [1:0]  s_cp;
    logic [1:0]  s_cn;
    logic        clk_lvl;
    logic [23:0] rx_shift;
    logic [4:0]  rx_bits;
    logic [15:0] reg_power;
    logic [15:0] reg_mode;
    logic        div_phase;
    logic        clk_lvl_q;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_rst <= 2'h3;
            s_pd  <= 2'h0;
            s_sck <= 3'h0;
            s_sel <= 3'h7;
            s_dat <= 2'h0;
            s_cp  <= 2'h0;
            s_cn  <= 2'h0;
            clk_lvl <= 1'b0;
        end
        else
        begin
            s_rst <= {s_rst[0], pins.active_low_reset_pin};
            s_pd  <= {s_pd[0], pins.power_down_pin};
            s_sck <= {s_sck[1:0], pins.ser_clk};
            s_sel <= {s_sel[1:0], pins.ser_sel_n};
            s_dat <= {s_dat[0], pins.ser_data};
            s_cp  <= {s_cp[0], pins.clock_pos_input};
            s_cn  <= {s_cn[0], pins.clock_neg_input};
            clk_lvl <= s_cp[1] & ~s_cn[1];
        end
    end

    wire       pin_reset   = ~s_rst[1];
    wire       sck_rise    = s_sck[1] & ~s_sck[2];
    wire       sel_low     = ~s_sel[1];
    wire       frame_end   = s_sel[1] & ~s_sel[2];
    wire       frame_ok    = frame_end && (rx_bits == 5'(FRAME_BITS));
    wire [7:0] rx_addr     = rx_shift[23:16];
    wire [15:0] rx_data    = rx_shift[15:0];
    wire       soft_reset  = frame_ok && rx_addr == ADDR_SOFT_RESET && rx_data == VAL_SOFT_RESET;
    wire       any_reset   = pin_reset | soft_reset;
    wire       pd_now      = s_pd[1] | reg_power[POWER_DOWN_BIT];
    wire       dual_now    = reg_mode[MODE_DUAL_BIT];
    wire       clk_rise    = clk_lvl & ~clk_lvl_q;

    // serial frame capture
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rx_shift <= 24'h000000;
            rx_bits  <= 5'h00;
        end
        else if (!sel_low)
        begin
            rx_bits <= frame_end ? rx_bits : 5'h00;
        end
        else if (sck_rise)
        begin
            rx_shift <= {rx_shift[22:0], s_dat[1]};
            rx_bits  <= (rx_bits == 5'h1F) ? rx_bits : rx_bits + 5'h01;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            reg_power    <= RST_POWER;
            reg_mode     <= RST_MODE;
            o_sel_first  <= RST_SEL;
            o_sel_second <= RST_SEL;
            o_phase      <= RST_PHASE;
        end
        else if (any_reset)
        begin
            reg_power    <= RST_POWER;
            reg_mode     <= RST_MODE;
            o_sel_first  <= RST_SEL;
            o_sel_second <= RST_SEL;
            o_phase      <= RST_PHASE;
        end
        else if (frame_ok)
        begin
            if (rx_addr == ADDR_POWER)
                reg_power <= rx_data;
            if (rx_addr == ADDR_MODE && pd_now)
                reg_mode <= rx_data;
            if (rx_addr == ADDR_SEL_FIRST)
                o_sel_first <= rx_data;
            if (rx_addr == ADDR_SEL_SECOND)
                o_sel_second <= rx_data;
            if (rx_addr == ADDR_PHASE)
                o_phase <= rx_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            clk_lvl_q          <= 1'b0;
            div_phase          <= 1'b0;
            o_sample_pulse     <= 1'b0;
            o_powered_down     <= 1'b0;
            o_dual_mode        <= 1'b0;
            o_div2             <= 1'b0;
        end
        else
        begin
            clk_lvl_q <= clk_lvl;
            if (pd_now)
                div_phase <= 1'b0;
            else if (clk_rise)
                div_phase <= ~div_phase;
            o_sample_pulse <= clk_rise & ~pd_now & (~reg_mode[MODE_DIV2_BIT] | ~div_phase);
            o_powered_down <= pd_now;
            o_dual_mode    <= dual_now;
            o_div2         <= reg_mode[MODE_DIV2_BIT];
        end
    end
endmodule
`default_nettype wire

// ===== hdl/adcsq_host.sv
// Purpose: host sequencer: reset, power down, mode change, input select
// Assumes: one command at a time, inputs held while o_busy is low
// Notes:   serial clock made by divider, data changes on falling edge
`default_nettype none
module adcsq_host
    import adcsq_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    adcsq_if.host            pins,
    input  wire logic        i_cmd_init,
    input  wire logic        i_cmd_mode,
    input  wire logic        i_cmd_select,
    input  wire logic        i_use_pins,
    input  wire logic        i_dual,
    input  wire logic        i_phase_en,
    input  wire logic [15:0] i_phase,
    input  wire logic [15:0] i_sel_first,
    input  wire logic [15:0] i_sel_second,
    output logic             o_busy,
    output logic             o_done
);
    typedef enum logic [7:0]
    {
        H_IDLE  = 8'h01,
        H_RST   = 8'h02,
        H_PDON  = 8'h04,
        H_PHASE = 8'h08,
        H_MODE  = 8'h10,
        H_PDOFF = 8'h20,
        H_SEL1  = 8'h40,
        H_SEL2  = 8'h80
    } adcsq_state_t;

    adcsq_state_t state;
    adcsq_state_t next_state;
    logic        launched;
    logic        use_pins;
    logic        dual;
    logic        phase_en;
    logic [15:0] phase;
    logic [15:0] sel1;
    logic [15:0] sel2;
    logic        ser_busy;
    logic        ser_gap;
    logic        ser_fin;
    logic [7:0]  ser_div;
    logic [4:0]  ser_bits;
    logic [23:0] ser_shift;
    logic        pin_run;
    logic        pin_fin;
    logic [7:0]  pin_cnt;

    wire is_pin_step = use_pins && (state == H_RST || state == H_PDON || state == H_PDOFF);
    wire skip_step   = (state == H_PHASE) && !phase_en;
    wire step_fin    = ser_fin | pin_fin;

    logic [23:0] step_word;
    always_comb
    begin
        step_word = 24'h000000;
        unique case (state)
            H_RST:   step_word = {ADDR_SOFT_RESET, VAL_SOFT_RESET};
            H_PDON:  step_word = {ADDR_POWER, VAL_POWER_DOWN};
            H_PHASE: step_word = {ADDR_PHASE, phase};
            H_MODE:  step_word = {ADDR_MODE, dual ? VAL_MODE_DUAL : VAL_MODE_SINGLE};
            H_PDOFF: step_word = {ADDR_POWER, VAL_ACTIVE};
            H_SEL1:  step_word = {ADDR_SEL_FIRST, sel1};
            H_SEL2:  step_word = {ADDR_SEL_SECOND, sel2};
            H_IDLE:  step_word = 24'h000000;
        endcase
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            H_IDLE:  next_state = H_IDLE;
            H_RST:   next_state = H_PDON;
            H_PDON:  next_state = H_PHASE;
            H_PHASE: next_state = H_MODE;
            H_MODE:  next_state = H_PDOFF;
            H_PDOFF: next_state = H_SEL1;
            H_SEL1:  next_state = H_SEL2;
            H_SEL2:  next_state = H_IDLE;
        endcase
    end

    wire launch = (state != H_IDLE) && !launched && !skip_step;
    wire ser_start = launch && !is_pin_step;
    wire pin_start = launch && is_pin_step;

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state    <= H_IDLE;
            launched <= 1'b0;
            o_busy   <= 1'b0;
            o_done   <= 1'b0;
        end
        else
        begin
            o_done <= 1'b0;
            if (state == H_IDLE)
            begin
                if (i_cmd_init)
                    state <= H_RST;
                else if (i_cmd_mode)
                    state <= H_PDON;
                else if (i_cmd_select)
                    state <= H_SEL1;
                o_busy <= i_cmd_init | i_cmd_mode | i_cmd_select;
            end
            else if (skip_step || step_fin)
            begin
                state    <= next_state;
                launched <= 1'b0;
                if (next_state == H_IDLE)
                begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
            end
            else if (launch)
                launched <= 1'b1;
        end
    end

    // command arguments held for the whole sequence
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            use_pins <= 1'b0;
            dual     <= 1'b0;
            phase_en <= 1'b0;
            phase    <= RST_PHASE;
            sel1     <= RST_SEL;
            sel2     <= RST_SEL;
        end
        else if (state == H_IDLE && (i_cmd_init | i_cmd_mode | i_cmd_select))
        begin
            use_pins <= i_use_pins;
            dual     <= i_dual;
            phase_en <= i_phase_en;
            phase    <= i_phase;
            sel1     <= i_sel_first;
            sel2     <= i_sel_second;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_run                   <= 1'b0;
            pin_fin                   <= 1'b0;
            pin_cnt                   <= 8'h00;
            pins.active_low_reset_pin <= 1'b1;
            pins.power_down_pin       <= 1'b0;
        end
        else
        begin
            pin_fin <= 1'b0;
            if (pin_start)
            begin
                pin_run <= 1'b1;
                pin_cnt <= 8'h00;
                if (state == H_RST)
                    pins.active_low_reset_pin <= 1'b0;
                else
                    pins.power_down_pin <= (state == H_PDON);
            end
            else if (pin_run)
            begin
                pin_cnt <= pin_cnt + 8'h01;
                if (pin_cnt == 8'(PIN_HOLD_CYC - 1))
                    pins.active_low_reset_pin <= 1'b1;
                if (pin_cnt == 8'(2 * PIN_HOLD_CYC - 1))
                begin
                    pin_run <= 1'b0;
                    pin_fin <= 1'b1;
                end
            end
        end
    end

    // serial write engine
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ser_busy       <= 1'b0;
            ser_gap        <= 1'b0;
            ser_fin        <= 1'b0;
            ser_div        <= 8'h00;
            ser_bits       <= 5'h00;
            ser_shift      <= 24'h000000;
            pins.ser_clk   <= 1'b0;
            pins.ser_sel_n <= 1'b1;
            pins.ser_data  <= 1'b0;
        end
        else
        begin
            ser_fin <= 1'b0;
            if (ser_start)
            begin
                ser_busy       <= 1'b1;
                ser_gap        <= 1'b0;
                ser_div        <= 8'h00;
                ser_bits       <= 5'h00;
                ser_shift      <= step_word;
                pins.ser_sel_n <= 1'b0;
                pins.ser_data  <= step_word[23];
                pins.ser_clk   <= 1'b0;
            end
            else if (ser_busy && ser_gap)
            begin
                ser_div <= ser_div + 8'h01;
                if (ser_div == 8'(2 * SCLK_HALF_CYC - 1))
                begin
                    ser_busy <= 1'b0;
                    ser_fin  <= 1'b1;
                end
            end
            else if (ser_busy)
            begin
                ser_div <= ser_div + 8'h01;
                if (ser_div == 8'(SCLK_HALF_CYC - 1))
                begin
                    ser_div <= 8'h00;
                    if (!pins.ser_clk)
                    begin
                        pins.ser_clk <= 1'b1;
                        ser_bits     <= ser_bits + 5'h01;
                    end
                    else
                    begin
                        pins.ser_clk <= 1'b0;
                        if (ser_bits == 5'(FRAME_BITS))
                        begin
                            pins.ser_sel_n <= 1'b1;
                            ser_gap        <= 1'b1;
                        end
                        else
                        begin
                            ser_shift     <= {ser_shift[22:0], 1'b0};
                            pins.ser_data <= ser_shift[22];
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/adcsq_chk.sv
// Purpose: wire checks on the serial link and control pins between the two ends
// Assumes: 50 MHz system clock, frames of 24 bits, 4-cycle serial half period
// Notes:   ports carry the interface signal names
`default_nettype none
module adcsq_chk
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic active_low_reset_pin,
    input wire logic power_down_pin,
    input wire logic ser_clk,
    input wire logic ser_sel_n,
    input wire logic ser_data,
    input wire logic clock_pos_input,
    input wire logic clock_neg_input
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    logic [5:0] rise_cnt;
    logic       clk_q;

    // counts serial clock rises inside a frame
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rise_cnt <= 6'h00;
            clk_q    <= 1'b0;
        end
        else
        begin
            clk_q    <= ser_clk;
            rise_cnt <= ser_sel_n ? 6'h00 : rise_cnt + {5'h00, ser_clk & ~clk_q};
        end
    end

    chk_frame_bit_count: assert property (
        $rose(ser_sel_n) |-> rise_cnt == 6'h18)
        else $error("frame closed with a bit count other than 24");
    chk_frame_gap_held: assert property (
        $rose(ser_sel_n) |-> ser_sel_n [*8])
        else $error("select high for fewer than 8 cycles between frames");
    chk_clk_idle_low: assert property (
        ser_sel_n |-> !ser_clk)
        else $error("serial clock high outside a frame");
    chk_clk_half_period: assert property (
        $rose(ser_clk) |-> ser_clk [*4] ##1 !ser_clk)
        else $error("serial clock high phase not 4 cycles");
    chk_data_on_fall: assert property (
        $changed(ser_data) && !ser_sel_n && !$past(ser_sel_n) |-> $fell(ser_clk))
        else $error("serial data moved away from a falling clock");
    chk_reset_pulse_width: assert property (
        $fell(active_low_reset_pin) |-> (!active_low_reset_pin) [*8]
            ##1 !active_low_reset_pin ##1 !active_low_reset_pin ##1 active_low_reset_pin)
        else $error("reset pin pulse not 10 cycles");
    chk_no_frame_reset: assert property (
        !active_low_reset_pin |-> ser_sel_n)
        else $error("frame while reset pin low");
    chk_pd_not_in_frame: assert property (
        $changed(power_down_pin) |-> ser_sel_n)
        else $error("power down pin moved inside a frame");
    chk_pd_step_settle: assert property (
        $changed(power_down_pin) |=> (ser_sel_n && $stable(power_down_pin)) [*8])
        else $error("next step started too soon after power down pin change");

    cov_frame: cover property ($rose(ser_sel_n));
    cov_reset_pin: cover property ($rose(active_low_reset_pin));
    cov_pd_pin: cover property ($fell(power_down_pin));
endmodule
`default_nettype wire

// ===== bench/adc_setup_mode_sequencer_bench.sv
// Purpose: host end and converter end joined, driven by command calls
// Assumes: 50 MHz system clock, 160 ns converter clock, cmos clock format
// Notes:   expected values come from the package constants and test settings
`default_nettype none
`define CHECK(name, exp, got) \
    begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); end end
module adc_setup_mode_sequencer_bench
    import adcsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk_sys;
    logic        reset_n;
    logic        conv_clk;
    logic        cmd_init;
    logic        cmd_mode;
    logic        cmd_select;
    logic        use_pins;
    logic        dual;
    logic        phase_en;
    logic [15:0] phase;
    logic [15:0] sel_first;
    logic [15:0] sel_second;
    logic        busy;
    logic        done;
    logic        powered_down;
    logic        dual_mode;
    logic        div2;
    logic [15:0] dev_sel_first;
    logic [15:0] dev_sel_second;
    logic [15:0] dev_phase;
    logic        sample_pulse;
    logic        seen_pd;
    int          num_errors;
    int          total_checks;

    adcsq_if pins_if ();
    assign pins_if.clock_pos_input = conv_clk;
    assign pins_if.clock_neg_input = 1'b0;

    adcsq_host adcsq_host_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .pins(pins_if),
        .i_cmd_init(cmd_init), .i_cmd_mode(cmd_mode), .i_cmd_select(cmd_select),
        .i_use_pins(use_pins), .i_dual(dual), .i_phase_en(phase_en), .i_phase(phase),
        .i_sel_first(sel_first), .i_sel_second(sel_second), .o_busy(busy), .o_done(done));
    adcsq_device adcsq_device_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .pins(pins_if),
        .o_powered_down(powered_down), .o_dual_mode(dual_mode), .o_div2(div2),
        .o_sel_first(dev_sel_first), .o_sel_second(dev_sel_second), .o_phase(dev_phase),
        .o_sample_pulse(sample_pulse));
    adcsq_chk adcsq_chk_i (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n),
        .active_low_reset_pin(pins_if.active_low_reset_pin),
        .power_down_pin(pins_if.power_down_pin), .ser_clk(pins_if.ser_clk),
        .ser_sel_n(pins_if.ser_sel_n), .ser_data(pins_if.ser_data),
        .clock_pos_input(pins_if.clock_pos_input), .clock_neg_input(pins_if.clock_neg_input));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial
    begin
        conv_clk = 1'b0;
        #7;
        forever #80 conv_clk = ~conv_clk;
    end
    always @(posedge clk_sys)
    begin
        if (powered_down === 1'b1)
            seen_pd <= 1'b1;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // pulses one command, waits for done, then lets the device settle
    task automatic run_cmd(input int which);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        seen_pd = 1'b0;
        cmd_init = (which == 0);
        cmd_mode = (which == 1);
        cmd_select = (which == 2);
        @(posedge clk_sys);
        #1;
        {cmd_init, cmd_mode, cmd_select} = 3'b000;
        while (n < 5000)
        begin
            @(posedge clk_sys);
            #1;
            if (done === 1'b1)
                break;
            n++;
        end
        `CHECK("done", 1'b1, done)
        repeat (10) @(posedge clk_sys);
        #1;
    endtask

    // counts sample pulses over 64 converter clock periods
    task automatic count_samples(input int exp);
        int n;
        n = 0;
        repeat (512)
        begin
            @(posedge clk_sys);
            #1;
            if (sample_pulse === 1'b1)
                n++;
        end
        `CHECK("samples", 1'b1, (n >= exp - 1 && n <= exp + 1))
    endtask

    initial
    begin
        num_errors = 0;
        total_checks = 0;
        reset_n = 1'b0;
        {cmd_init, cmd_mode, cmd_select, use_pins, dual, phase_en} = 6'h00;
        phase = 16'h0000;
        sel_first = VAL_SEL_INPUT1;
        sel_second = VAL_SEL_INPUT1;
        seen_pd = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        `CHECK("sel reset", RST_SEL, dev_sel_first)
        `CHECK("phase reset", RST_PHASE, dev_phase)
        $display("test 0 reset values done");

        phase_en = 1'b1;
        phase = 16'h00A5;
        run_cmd(0);
        `CHECK("pd seen", 1'b1, seen_pd)
        `CHECK("phase", 16'h00A5, dev_phase)
        `CHECK("dual", 1'b0, dual_mode)
        `CHECK("div2", 1'b0, div2)
        `CHECK("active", 1'b0, powered_down)
        `CHECK("sel first", VAL_SEL_INPUT1, dev_sel_first)
        `CHECK("sel second", VAL_SEL_INPUT1, dev_sel_second)
        count_samples(64);
        $display("test 1 serial init single done");

        use_pins = 1'b1;
        dual = 1'b1;
        phase_en = 1'b0;
        sel_first = 16'h0404;
        sel_second = 16'h0808;
        run_cmd(0);
        `CHECK("phase cleared", RST_PHASE, dev_phase)
        `CHECK("pd seen", 1'b1, seen_pd)
        `CHECK("dual", 1'b1, dual_mode)
        `CHECK("div2", 1'b1, div2)
        `CHECK("active", 1'b0, powered_down)
        `CHECK("sel first", 16'h0404, dev_sel_first)
        `CHECK("sel second", 16'h0808, dev_sel_second)
        count_samples(32);
        $display("test 2 pin init dual done");

        use_pins = 1'b0;
        sel_first = VAL_SEL_INPUT2;
        sel_second = VAL_SEL_INPUT2;
        run_cmd(2);
        `CHECK("no pd", 1'b0, seen_pd)
        `CHECK("sel first", VAL_SEL_INPUT2, dev_sel_first)
        `CHECK("sel second", VAL_SEL_INPUT2, dev_sel_second)
        `CHECK("mode kept", 1'b1, dual_mode)
        $display("test 3 select on the fly done");

        dual = 1'b0;
        run_cmd(1);
        `CHECK("pd seen", 1'b1, seen_pd)
        `CHECK("dual", 1'b0, dual_mode)
        `CHECK("div2", 1'b0, div2)
        `CHECK("active", 1'b0, powered_down)
        count_samples(64);
        $display("test 4 mode change done");

        @(posedge clk_sys);
        #1;
        cmd_select = 1'b1;
        @(posedge clk_sys);
        #1;
        cmd_select = 1'b0;
        repeat (20) @(posedge clk_sys);
        #1;
        `CHECK("busy mid command", 1'b1, busy)
        reset_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        `CHECK("sel after reset", RST_SEL, dev_sel_first)
        `CHECK("busy after reset", 1'b0, busy)
        $display("test 5 mid run reset done");
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
